/* core/hoc_osc_ctrl.sv */
`timescale 1ns/100ps
// Overview of operation
// - start-mode above 1 gates oscillator per measurement
// - mode 0 off except during calibration, 1 on, 2..7 settle delays
// - settle and calibration timed from reference clock
// - reference oscillator always runs, never disabled
// - selector1 equals 7 drives reference to fire-in
// - selector2 equals 7 drives reference/8 to start-enable
// - calibration start/stop pulses from reference clock
// - store result first, then raise interrupt flag
// - calibration command triggers calibration using period count
// - period count 0..3 selects 2,4,8,16 periods
// - result in divided high-speed periods, 16.16 format
module hoc_osc_ctrl (
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // clocks sampled as levels
  input  wire logic              lfClkIn,
  input  wire logic              highSpeedClock,
  // commands and configuration
  input  wire hoc_pkg::hoc_cmd_t cmd,
  input  wire hoc_pkg::hoc_cfg_t cfg,
  input  wire logic              measureDone,
  input  wire logic              irqClear,
  // oscillator and measurement control
  output logic                   hsOscEnable,
  output logic                   measureStart,
  output logic                   calStartPulse,
  output logic                   calStopPulse,
  output logic [31:0]            calResult,
  output logic                   calIrq,
  // test pins
  output logic                   fireInOut,
  output logic                   fireInOe,
  output logic                   startEnOut,
  output logic                   startEnOe
);

  hoc_pkg::hoc_regs_t q;
  hoc_pkg::hoc_regs_t d;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // settle delay in reference periods for a start mode
  function automatic logic [7:0] settleLen(input logic [2:0] mode);
    unique case (mode)
      3'h2:    settleLen = hoc_pkg::SETTLE_C2;
      3'h3:    settleLen = hoc_pkg::SETTLE_C3;
      3'h4:    settleLen = hoc_pkg::SETTLE_C4;
      default: settleLen = hoc_pkg::SETTLE_C5;
    endcase
  endfunction

  // prescaler terminal value for the high-speed divider
  function automatic logic [1:0] preLast(input logic [1:0] div);
    unique case (div)
      hoc_pkg::HS_DIV_BY1: preLast = 2'h0;
      hoc_pkg::HS_DIV_BY2: preLast = 2'h1;
      default:             preLast = 2'h3; // 2 and 3 both divide by 4
    endcase
  endfunction

  logic       lfRise;
  logic       hsRise;
  logic       anyMeas;
  logic [4:0] calPeriods;

  // edges of the sampled clocks; the reference is never gated here
  assign lfRise     = lfClkIn & ~q.lfPrev;
  assign hsRise     = highSpeedClock & ~q.hsPrev;
  assign anyMeas    = cmd.tofMeasure | cmd.tofMeasureRepeat |
                      cmd.tempMeasure | cmd.tempMeasureRepeat;
  assign calPeriods = 5'(5'h2 << cfg.calPeriodCount);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    d           = q;
    d.lfPrev    = lfClkIn;
    d.hsPrev    = highSpeedClock;
    d.measStart = 1'b0;
    d.calStart  = 1'b0;
    d.calStop   = 1'b0;
    d.irqPend   = 1'b0;
    // free divide by 8 of the reference
    if (lfRise) begin
      d.lfDiv = q.lfDiv + 3'h1;
    end
    unique case (q.st)
      hoc_pkg::ST_IDLE: begin
        if (cmd.calResonator) begin
          d.st     = hoc_pkg::ST_CALARM;
          d.perCnt = 5'h0;
          d.hsCnt  = 16'h0;
          d.hsPre  = 2'h0;
        end else if (anyMeas) begin
          if (cfg.hsOscStartMode > hoc_pkg::START_MODE_ON) begin
            d.st        = hoc_pkg::ST_SETTLE;
            d.settleCnt = settleLen(cfg.hsOscStartMode);
          end else begin
            d.st        = hoc_pkg::ST_MEAS;
            d.measStart = 1'b1;
          end
        end
      end
      hoc_pkg::ST_SETTLE: begin
        // delay counted in reference periods, not system cycles
        if (lfRise) begin
          d.settleCnt = q.settleCnt - 8'h1;
          if (q.settleCnt == 8'h1) begin
            d.st        = hoc_pkg::ST_MEAS;
            d.measStart = 1'b1;
          end
        end
      end
      hoc_pkg::ST_MEAS: begin
        if (measureDone) begin
          d.st = hoc_pkg::ST_IDLE;
        end
      end
      hoc_pkg::ST_CALARM: begin
        // aligning to a reference edge removes a partial first period
        if (lfRise) begin
          d.st       = hoc_pkg::ST_CALRUN;
          d.calStart = 1'b1;
        end
      end
      hoc_pkg::ST_CALRUN: begin
        // counts divided high-speed periods; the start-enable input is
        // assumed held by the controller while this runs
        if (hsRise) begin
          if (q.hsPre == preLast(cfg.hsClockDivider)) begin
            d.hsPre = 2'h0;
            d.hsCnt = q.hsCnt + 16'h1;
          end else begin
            d.hsPre = q.hsPre + 2'h1;
          end
        end
        if (lfRise) begin
          d.perCnt = q.perCnt + 5'h1;
          if (q.perCnt + 5'h1 == calPeriods) begin
            d.st        = hoc_pkg::ST_IDLE;
            d.calStop   = 1'b1;
            // fraction left at zero: sub-period phase not resolved here
            d.calResult = {q.hsCnt, {hoc_pkg::RES_FRAC_BITS{1'b0}}};
            d.irqPend   = 1'b1;
          end
        end
      end
      default: d.st = hoc_pkg::ST_IDLE;
    endcase
    // flag follows the stored result by one cycle; set beats clear
    d.calIrq = q.irqPend | (q.calIrq & ~irqClear);
    // mode 1 runs it continuously; mode 0 keeps it off for measurements,
    // while calibration still needs the resonator and turns it on in any mode
    d.hsOscEn = (cfg.hsOscStartMode == hoc_pkg::START_MODE_ON) |
                ((cfg.hsOscStartMode != hoc_pkg::START_MODE_OFF) &
                 (d.st != hoc_pkg::ST_IDLE)) |
                (d.st == hoc_pkg::ST_CALARM) | (d.st == hoc_pkg::ST_CALRUN);
    // test outputs of the reference clock
    d.fireInOe   = (cfg.testOut1Select == hoc_pkg::TEST_SEL_LFCLK);
    d.fireInOut  = d.fireInOe & lfClkIn;
    d.startEnOe  = (cfg.testOut2Select == hoc_pkg::TEST_SEL_LFCLK);
    d.startEnOut = d.startEnOe & d.lfDiv[2];
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q    <= '0;
      q.st <= hoc_pkg::ST_IDLE;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign hsOscEnable   = q.hsOscEn;
  assign measureStart  = q.measStart;
  assign calStartPulse = q.calStart;
  assign calStopPulse  = q.calStop;
  assign calResult     = q.calResult;
  assign calIrq        = q.calIrq;
  assign fireInOut     = q.fireInOut;
  assign fireInOe      = q.fireInOe;
  assign startEnOut    = q.startEnOut;
  assign startEnOe     = q.startEnOe;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_settle_oscon: assert property (
    clkEn && q.st == hoc_pkg::ST_SETTLE |=> hsOscEnable)
    else $error("oscillator off while settling");
  chk_mode_off: assert property (
    clkEn && q.st == hoc_pkg::ST_IDLE && cfg.hsOscStartMode == hoc_pkg::START_MODE_OFF
    && !anyMeas && !cmd.calResonator |=> !hsOscEnable)
    else $error("oscillator on in mode off while idle");
  chk_meas_off: assert property (
    clkEn && q.st == hoc_pkg::ST_MEAS && cfg.hsOscStartMode == hoc_pkg::START_MODE_OFF
    |=> !hsOscEnable)
    else $error("oscillator on in mode off while measuring");
  chk_settle_step: assert property (
    clkEn && q.st == hoc_pkg::ST_SETTLE && !lfRise |=> $stable(q.settleCnt))
    else $error("settle count moved without reference edge");
  chk_fire_pin: assert property (
    clkEn && cfg.testOut1Select == hoc_pkg::TEST_SEL_LFCLK |=> fireInOe)
    else $error("fire-in pin not driven");
  chk_start_pin: assert property (
    clkEn && cfg.testOut2Select != hoc_pkg::TEST_SEL_LFCLK |=> !startEnOe)
    else $error("start-enable driven when not selected");
  chk_cal_order: assert property (
    calStopPulse |-> $past(q.st) == hoc_pkg::ST_CALRUN)
    else $error("stop pulse outside calibration");
  chk_irq_after: assert property (
    clkEn && calStopPulse |=> calIrq && $stable(calResult))
    else $error("flag not raised after result");
  chk_cal_trigger: assert property (
    clkEn && q.st == hoc_pkg::ST_IDLE && cmd.calResonator |=> q.st == hoc_pkg::ST_CALARM)
    else $error("calibration command ignored");
  chk_period_bound: assert property (
    q.st == hoc_pkg::ST_CALRUN |-> q.perCnt < calPeriods)
    else $error("period count overran selection");
  chk_result_frac: assert property (
    calResult[15:0] == 16'h0)
    else $error("fraction field nonzero");
  chk_hs_count: assert property (
    clkEn && q.st == hoc_pkg::ST_CALRUN && !hsRise |=> $stable(q.hsCnt))
    else $error("high-speed count moved without resonator edge");

  cov_meas_settled: cover property (q.st == hoc_pkg::ST_SETTLE ##1 measureStart);
  cov_cal_done:     cover property (calStopPulse ##1 calIrq);
  cov_irq_clear:    cover property (calIrq ##1 !calIrq);

endmodule

/* core/hoc_pkg.sv */
package hoc_pkg;

  // --------------------------------------------------------------
  // reference clock and settling delays
  // --------------------------------------------------------------
  localparam longint LF_CLK_HZ      = 64'd32768;
  localparam longint NS_PER_S       = 64'd1000000000;
  localparam longint SETTLE_T2_NS   = 64'd480000;   // 480 us
  localparam longint SETTLE_T3_NS   = 64'd1460000;  // 1.46 ms
  localparam longint SETTLE_T4_NS   = 64'd2440000;  // 2.44 ms
  localparam longint SETTLE_T5_NS   = 64'd5140000;  // 5.14 ms
  // least times, so counts of reference periods round up
  localparam logic [7:0] SETTLE_C2 = 8'((SETTLE_T2_NS * LF_CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [7:0] SETTLE_C3 = 8'((SETTLE_T3_NS * LF_CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [7:0] SETTLE_C4 = 8'((SETTLE_T4_NS * LF_CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam logic [7:0] SETTLE_C5 = 8'((SETTLE_T5_NS * LF_CLK_HZ + NS_PER_S - 1) / NS_PER_S);

  // --------------------------------------------------------------
  // field encodings
  // --------------------------------------------------------------
  localparam logic [2:0] START_MODE_OFF = 3'h0;
  localparam logic [2:0] START_MODE_ON  = 3'h1;
  localparam logic [2:0] TEST_SEL_LFCLK = 3'h7;
  localparam logic [1:0] HS_DIV_BY1     = 2'h0;
  localparam logic [1:0] HS_DIV_BY2     = 2'h1;
  localparam int         RES_FRAC_BITS  = 16;

  // --------------------------------------------------------------
  // controller states, gray along idle-settle-measure, idle-arm-run
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETTLE = 3'h1,
    ST_MEAS   = 3'h3,
    ST_CALARM = 3'h4,
    ST_CALRUN = 3'h6
  } hoc_state_t;

  // command strobes from the serial port decoder
  typedef struct packed {
    logic tofMeasure;
    logic tofMeasureRepeat;
    logic tempMeasure;
    logic tempMeasureRepeat;
    logic calResonator;
  } hoc_cmd_t;

  // configuration fields
  typedef struct packed {
    logic [2:0] hsOscStartMode;
    logic [2:0] testOut1Select;
    logic [2:0] testOut2Select;
    logic [1:0] calPeriodCount;
    logic [1:0] hsClockDivider;
  } hoc_cfg_t;

  // whole block state
  typedef struct packed {
    hoc_state_t  st;
    logic        lfPrev;
    logic        hsPrev;
    logic [2:0]  lfDiv;
    logic [7:0]  settleCnt;
    logic [4:0]  perCnt;
    logic [1:0]  hsPre;
    logic [15:0] hsCnt;
    logic [31:0] calResult;
    logic        irqPend;
    logic        calIrq;
    logic        hsOscEn;
    logic        measStart;
    logic        calStart;
    logic        calStop;
    logic        fireInOut;
    logic        fireInOe;
    logic        startEnOut;
    logic        startEnOe;
  } hoc_regs_t;

endpackage

/* sim/hoc_far_end.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side: reference clock, resonator clock, measuring unit
// ------------------------------------------------------------
module hoc_far_end (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // measuring unit handshake
  input  wire logic       measureStart,
  input  wire logic [7:0] doneLat,
  output logic            measureDone,
  // clock levels
  output logic            lfClkIn,
  output logic            highSpeedClock
);
  logic [7:0] phase = 8'h00;
  logic [7:0] busyCnt;

  // reference scaled to 32 cycles a period, else settles take too long
  always @(negedge clk_sys) phase <= phase + 8'h01;
  assign lfClkIn        = phase[4];
  // resonator edges kept apart from reference edges
  assign highSpeedClock = phase[1] ^ phase[0];

  // measurement ends doneLat cycles after start, prompt or slow
  always @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      busyCnt     <= 8'h00;
      measureDone <= 1'b0;
    end else begin
      measureDone <= (busyCnt == 8'h01);
      if (measureStart) busyCnt <= doneLat;
      else if (busyCnt != 8'h00) busyCnt <= busyCnt - 8'h01;
    end
  end
endmodule

/* sim/hoc_osc_ctrl_tb.sv */
`timescale 1ns/100ps
module hoc_osc_ctrl_tb;
  logic              clk_sys, rst, clkEn, irqClear, measureDone, lfClkIn, highSpeedClock;
  logic              hsOscEnable, measureStart, calStartPulse, calStopPulse, calIrq;
  logic              fireInOut, fireInOe, startEnOut, startEnOe, lfSeen, prevOut;
  logic [31:0]       calResult;
  logic [7:0]        doneLat;
  logic [3:0]        frozen;
  hoc_pkg::hoc_cmd_t cmd;
  hoc_pkg::hoc_cfg_t cfg;
  int                n_fail, samples_checked, lfRises, calStarts, ups;

  hoc_osc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .lfClkIn(lfClkIn),
    .highSpeedClock(highSpeedClock), .cmd(cmd), .cfg(cfg), .measureDone(measureDone),
    .irqClear(irqClear), .hsOscEnable(hsOscEnable), .measureStart(measureStart),
    .calStartPulse(calStartPulse), .calStopPulse(calStopPulse), .calResult(calResult),
    .calIrq(calIrq), .fireInOut(fireInOut), .fireInOe(fireInOe),
    .startEnOut(startEnOut), .startEnOe(startEnOe));
  hoc_far_end far (.clk_sys(clk_sys), .rst(rst), .measureStart(measureStart),
    .doneLat(doneLat), .measureDone(measureDone), .lfClkIn(lfClkIn),
    .highSpeedClock(highSpeedClock));

  // ------------------------------------------------------------
  // clock and edge watch, sampled like the design samples
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    lfSeen <= lfClkIn;
    if (lfClkIn && !lfSeen) lfRises <= lfRises + 1;
    if (calStartPulse) calStarts <= calStarts + 1;
  end

  // ------------------------------------------------------------
  // compare, wait and closing tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: pick = measureStart;
      1: pick = calStartPulse;
      2: pick = calStopPulse;
      default: pick = measureDone;
    endcase
  endfunction
  // bounded wait; a pulse stands one cycle so every negedge is looked at
  task automatic await(input int w);
    for (int n = 0; pick(w) !== 1'b1; n++) begin
      if (n > 9000) begin
        cmp(32'h0, 32'h1);
        end_of_test();
      end
      @(negedge clk_sys);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // measurement with settle, every strobe kind
  // ------------------------------------------------------------
  task automatic meas(input logic [2:0] m, input int s);
    logic [7:0] n;
    int         base;
    int         calBase;
    n = m == 3'h2 ? hoc_pkg::SETTLE_C2 : m == 3'h3 ? hoc_pkg::SETTLE_C3 :
        m == 3'h4 ? hoc_pkg::SETTLE_C4 : m > 3'h4 ? hoc_pkg::SETTLE_C5 : 8'h00;
    cfg.hsOscStartMode = m;
    doneLat = {2'h0, m, 3'h2};
    // start on a high reference so no rise lands on the command edge
    for (int k = 0; k < 64 && lfClkIn !== 1'b1; k++) @(negedge clk_sys);
    // counters belong to the edge watch; only their offsets are taken here
    base = lfRises;
    calBase = calStarts;
    cmd = 5'h10 >> s;
    tick(1);
    cmd = 5'h00;
    if (m == 3'h2) begin
      // busy: a second start and a calibration must both be dropped
      tick(3);
      cmd = 5'h11;
      tick(1);
      cmd = 5'h00;
    end
    await(0);
    cmp(lfRises - base, {24'h0, n});
    cmp(hsOscEnable, {31'h0, m != 3'h0});
    await(3);
    tick(2);
    cmp(hsOscEnable, {31'h0, m == 3'h1});
    cmp(calStarts - calBase, 0);
    $display("test settle mode %0d done", m);
  endtask

  // ------------------------------------------------------------
  // calibration: 8 resonator rises per reference period
  // ------------------------------------------------------------
  task automatic cal(input logic [1:0] c, input logic [1:0] d);
    logic [15:0] e;
    int          base;
    e = 16'(32'h10 << c) >> (d == 2'h0 ? 0 : d == 2'h1 ? 1 : 2);
    cfg.hsOscStartMode = hoc_pkg::START_MODE_OFF;
    cfg.calPeriodCount = c;
    cfg.hsClockDivider = d;
    cmd = 5'h01;
    tick(1);
    cmd = 5'h00;
    await(1);
    base = lfRises;
    // host leaves the start input enabled and sends nothing until the stop
    await(2);
    cmp(lfRises - base, 32'h2 << c);
    cmp(calResult, {e, 16'h0});
    cmp(calIrq, 0);
    cmp(hsOscEnable, 0);
    tick(1);
    cmp(calIrq, 1);
    irqClear = 1'b1;
    tick(1);
    irqClear = 1'b0;
    tick(1);
    cmp(calIrq, 0);
    $display("test calibration %0d/%0d done", c, d);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, clkEn, irqClear, doneLat, cmd, cfg} = '0;
    {n_fail, samples_checked} = '0;
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    clkEn = 1'b1;
    cmp({28'h0, hsOscEnable, calIrq, fireInOe, startEnOe}, 32'h0);
    cmp(calResult, 32'h0);
    for (int m = 0; m < 8; m++) meas(3'(m), m % 4);
    for (int i = 0; i < 4; i++) cal(2'(i), 2'(i));
    // a single and a repeated time-of-flight measurement share the calibration just taken
    meas(hoc_pkg::START_MODE_ON, 0);
    meas(hoc_pkg::START_MODE_ON, 1);
    cmp(calResult, 32'h0020_0000);
    // test pins: selector 7 drives reference and reference/8
    cfg.testOut1Select = hoc_pkg::TEST_SEL_LFCLK;
    cfg.testOut2Select = hoc_pkg::TEST_SEL_LFCLK;
    tick(2);
    ups = 0;
    prevOut = startEnOut;
    // 512 steps of a 256-cycle divided clock always hold two rises
    for (int k = 0; k < 513; k++) begin
      cmp({fireInOe, startEnOe, fireInOut}, {2'b11, lfSeen});
      ups += (startEnOut && !prevOut);
      prevOut = startEnOut;
      tick(1);
    end
    cmp(ups, 2);
    // clock enable low freezes the pins while the reference runs on
    clkEn = 1'b0;
    frozen = {fireInOe, startEnOe, fireInOut, startEnOut};
    tick(40);
    cmp({28'h0, fireInOe, startEnOe, fireInOut, startEnOut}, {28'h0, frozen});
    clkEn = 1'b1;
    cfg.testOut1Select = 3'h6;
    cfg.testOut2Select = 3'h6;
    tick(2);
    cmp({fireInOe, startEnOe, fireInOut, startEnOut}, 0);
    $display("test pins done");
    end_of_test();
  end
endmodule
